// [rtl/rtc_port_cfg.svh]
// constants for the rtc serial port: slave address, pointer layout, bus timing
// assumes a 250 MHz core clock; included by bare name by every end
`ifndef RTC_PORT_CFG_SVH
`define RTC_PORT_CFG_SVH

// fixed slave address byte d0h, direction bit stripped
`define SLAVE_ADDR 7'h68
`define DIR_READ 1'b1
`define BYTE_COUNT 8
`define PTR_W 3
`define PTR_FIRST 3'h0
`define BIT_ACK 4'h8
`define BIT_MSB 3'h7

// master bus timing: one bit is four quarter periods
`define CORE_PERIOD_PS 4000
`define SCL_QTR_NS 2500
`define SCL_QTR_CYC ((`SCL_QTR_NS * 1000 + `CORE_PERIOD_PS - 1) / `CORE_PERIOD_PS)
// bench link speed: 80 ns scl period keeps runs short; the device side does not care
`define FAST_QTR_CYC 10'h005
`define SEQ_LAST 6'h07
`define BYTE_LAST 6'h23

`endif

// [rtl/rtc_port_pkg.sv]
// types shared by both ends of the rtc serial link
// assumes rtc_port_cfg.svh supplies the numeric constants
package rtc_port_pkg;

   typedef enum logic [1:0] {CMD_START, CMD_STOP, CMD_WRITE, CMD_READ} cmd_e;

   typedef enum logic [2:0] {DS_ADDR, DS_WADDR, DS_WDATA, DS_READ, DS_IGNORE} dev_state_e;

   typedef enum logic [2:0] {HS_IDLE, HS_START, HS_HOLD, HS_BYTE, HS_STOP} host_state_e;

endpackage

// [rtl/rtc_link_if.sv]
// two-wire link between bus master and rtc port, open-drain with pull-ups
// assumes the bench instantiates it and hands one modport to each end
`timescale 1ns/1ps
interface rtc_link_if;
   logic scl_o;
   logic scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl;
   logic sda;

   // wired-and with pull-up: any enabled low driver wins
   assign scl = !(scl_oe && !scl_o);
   assign sda = !((m_sda_oe && !m_sda_o) || (d_sda_oe && !d_sda_o));

   modport master (output scl_o, output scl_oe, output m_sda_o, output m_sda_oe,
                   input scl, input sda);
   modport device (output d_sda_o, output d_sda_oe, input scl, input sda);
endinterface

// [rtl/level_sync.sv]
// two flip-flop synchroniser for a group of independent levels
// assumes each bit is a slow level; no word coherence across bits
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_q;
   logic [W-1:0] meta_d;
   logic [W-1:0] sync_d;

   always_comb begin
      meta_d = i_d;
      sync_d = meta_q;
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_q <= '0;
         o_q <= '0;
      end else begin
         meta_q <= meta_d;
         o_q <= sync_d;
      end
   end
endmodule

// [rtl/rtc_serial_slave_port.sv]
// rtc two-wire slave port: byte engine on the link clock, framing on the core clock
// assumes scl/sda from rtc_link_if, i_supply_ok from an async supply comparator
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module rtc_serial_slave_port (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic I_SUPPLY_OK,
   rtc_link_if.device LINK,
   output logic O_MAIN_SUPPLY,
   output logic O_FRAME_ACTIVE,
   output logic O_WR_STB,
   output logic [`PTR_W-1:0] O_WR_ADDR,
   output logic [7:0] O_WR_DATA
);
   import rtc_port_pkg::*;

   // ---------------- core clock domain ----------------
   logic [3:0] sync_s;
   logic scl_s;
   logic sda_s;
   logic sup_s;
   logic tgl_s;
   logic start_c;
   logic stop_c;
   logic sda_p_q, sda_p_d;
   logic frame_q, frame_d;
   logic clr_q, clr_d;
   logic ptr_clr_q, ptr_clr_d;
   logic tgl_p_q, tgl_p_d;
   logic sup_q, sup_d;
   logic wr_stb_q, wr_stb_d;
   logic [`PTR_W-1:0] wr_addr_q, wr_addr_d;
   logic [7:0] wr_data_q, wr_data_d;

   // ---------------- link clock domain ----------------
   logic eng_rst_n;
   logic ptr_rst_n;
   logic addr_hit;
   logic [3:0] bit_q, bit_d;
   logic [7:0] shift_q, shift_d;
   dev_state_e st_q, st_d;
   logic adv;
   logic we;
   logic ptr_ld;
   logic [`PTR_W-1:0] ptr_q, ptr_d;
   logic lk_tgl_q, lk_tgl_d;
   logic [`PTR_W-1:0] lk_addr_q, lk_addr_d;
   logic [7:0] lk_data_q, lk_data_d;
   logic [7:0] mem_q [`BYTE_COUNT];
   logic oe_q, oe_d;

   level_sync #(
      .W(4)
   ) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_d({LINK.scl, LINK.sda, I_SUPPLY_OK, lk_tgl_q}),
      .o_q(sync_s)
   );

   assign scl_s = sync_s[3];
   assign sda_s = sync_s[2];
   assign sup_s = sync_s[1];
   assign tgl_s = sync_s[0];

   // framing watches the synchronised pins; the link clock stops outside frames,
   // so only this domain can see start and stop and reset the byte engine
   always_comb begin
      start_c = scl_s && sda_p_q && !sda_s;
      stop_c = scl_s && !sda_p_q && sda_s;
      sda_p_d = sda_s;
      sup_d = sup_s;
      ptr_clr_d = !sup_s;
      tgl_p_d = tgl_s;
      frame_d = frame_q;
      clr_d = clr_q;
      wr_stb_d = 1'b0;
      wr_addr_d = wr_addr_q;
      wr_data_d = wr_data_q;
      if (!sup_s) begin
         frame_d = 1'b0;
         clr_d = 1'b1;
      end else if (start_c) begin
         frame_d = 1'b1;
         clr_d = 1'b1;
      end else if (stop_c) begin
         frame_d = 1'b0;
         clr_d = 1'b1;
      end else if (frame_q && !scl_s) begin
         // release only while scl is low, far from the next rising edge
         clr_d = 1'b0;
      end
      // link side holds address and data steady for a whole byte time
      if (sup_s && (tgl_s != tgl_p_q)) begin
         wr_stb_d = 1'b1;
         wr_addr_d = lk_addr_q;
         wr_data_d = lk_data_q;
      end
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         sda_p_q <= 1'b1;
         sup_q <= 1'b0;
         ptr_clr_q <= 1'b1;
         tgl_p_q <= 1'b0;
         frame_q <= 1'b0;
         clr_q <= 1'b1;
         wr_stb_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= 8'h00;
      end else begin
         sda_p_q <= sda_p_d;
         sup_q <= sup_d;
         ptr_clr_q <= ptr_clr_d;
         tgl_p_q <= tgl_p_d;
         frame_q <= frame_d;
         clr_q <= clr_d;
         wr_stb_q <= wr_stb_d;
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
      end
   end

   assign O_MAIN_SUPPLY = sup_q;
   assign O_FRAME_ACTIVE = frame_q;
   assign O_WR_STB = wr_stb_q;
   assign O_WR_ADDR = wr_addr_q;
   assign O_WR_DATA = wr_data_q;

   // registered core levels act as async resets of the link-side flops, all but the byte store mem_q
   assign eng_rst_n = !clr_q;
   assign ptr_rst_n = !ptr_clr_q;
   assign addr_hit = (shift_q[7:1] == `SLAVE_ADDR);

   // byte engine: samples sda on rising scl
   always_comb begin
      bit_d = bit_q + 4'h1;
      shift_d = {shift_q[6:0], LINK.sda};
      st_d = st_q;
      adv = 1'b0;
      we = 1'b0;
      ptr_ld = 1'b0;
      if (bit_q == `BIT_ACK) begin
         bit_d = 4'h0;
         shift_d = shift_q;
         case (st_q)
            DS_ADDR: begin
               if (!addr_hit) begin
                  st_d = DS_IGNORE;
               end else if (shift_q[0] == `DIR_READ) begin
                  st_d = DS_READ;
               end else begin
                  st_d = DS_WADDR;
               end
            end
            DS_WADDR: begin
               ptr_ld = 1'b1;
               st_d = DS_WDATA;
            end
            DS_WDATA: begin
               we = 1'b1;
               adv = 1'b1;
            end
            DS_READ: begin
               if (!LINK.sda) begin
                  adv = 1'b1;
               end else begin
                  st_d = DS_IGNORE;
               end
            end
            default: begin
               st_d = DS_IGNORE;
            end
         endcase
      end
   end

   always_ff @(posedge LINK.scl or negedge eng_rst_n) begin
      if (!eng_rst_n) begin
         bit_q <= 4'h0;
         shift_q <= 8'h00;
         st_q <= DS_ADDR;
      end else begin
         bit_q <= bit_d;
         shift_q <= shift_d;
         st_q <= st_d;
      end
   end

   // pointer survives stop and repeated start; only supply loss or I_RST_N clears it
   always_comb begin
      ptr_d = ptr_q;
      lk_tgl_d = lk_tgl_q;
      lk_addr_d = lk_addr_q;
      lk_data_d = lk_data_q;
      if (ptr_ld) begin
         ptr_d = shift_q[`PTR_W-1:0];
      end else if (adv) begin
         ptr_d = ptr_q + 3'h1;
      end
      if (we) begin
         lk_tgl_d = !lk_tgl_q;
         lk_addr_d = ptr_q;
         lk_data_d = shift_q;
      end
   end

   always_ff @(posedge LINK.scl or negedge ptr_rst_n) begin
      if (!ptr_rst_n) begin
         ptr_q <= `PTR_FIRST;
         lk_tgl_q <= 1'b0;
         lk_addr_q <= '0;
         lk_data_q <= 8'h00;
      end else begin
         ptr_q <= ptr_d;
         lk_tgl_q <= lk_tgl_d;
         lk_addr_q <= lk_addr_d;
         lk_data_q <= lk_data_d;
      end
   end

   // clock and calendar bytes; no reset, contents are kept across frames
   always_ff @(posedge LINK.scl) begin
      if (we) begin
         mem_q[ptr_q] <= shift_q;
      end
   end

   // sda driver changes on falling scl, or clears at once on the byte engine reset
   always_comb begin
      oe_d = 1'b0;
      if (bit_q == `BIT_ACK) begin
         oe_d = (st_q == DS_ADDR && addr_hit) || (st_q == DS_WADDR)
             || (st_q == DS_WDATA);
      end else if (st_q == DS_READ) begin
         oe_d = !mem_q[ptr_q][`BIT_MSB - bit_q[2:0]];
      end
   end

   always_ff @(negedge LINK.scl or negedge eng_rst_n) begin
      if (!eng_rst_n) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= oe_d;
      end
   end

   assign LINK.d_sda_o = 1'b0;
   assign LINK.d_sda_oe = oe_q;
endmodule

// [rtl/rtc_bus_master.sv]
// two-wire bus master: byte-level command port, scl made by a quarter divider
// assumes a single master; no clock stretching or arbitration on the link
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module rtc_bus_master #(
   parameter logic [9:0] QTR_CYC = 10'(`SCL_QTR_CYC)
) (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic I_CMD_VALID,
   input wire rtc_port_pkg::cmd_e I_CMD,
   input wire logic [7:0] I_CMD_DATA,
   input wire logic I_CMD_ACK,
   output logic O_CMD_READY,
   output logic O_RSP_VALID,
   output logic [7:0] O_RSP_DATA,
   output logic O_RSP_NACK,
   rtc_link_if.master LINK
);
   import rtc_port_pkg::*;

   logic [1:0] pin_s;
   logic adv;
   logic [3:0] bit_n;
   host_state_e st_q, st_d;
   logic [5:0] step_q, step_d;
   logic [9:0] tick_q, tick_d;
   logic rd_q, rd_d;
   logic ack_q, ack_d;
   logic [7:0] tx_q, tx_d;
   logic [7:0] rx_q, rx_d;
   logic scl_oe_q, scl_oe_d;
   logic sda_oe_q, sda_oe_d;
   logic rdy_q, rdy_d;
   logic rsp_v_q, rsp_v_d;
   logic nack_q, nack_d;

   level_sync #(
      .W(2)
   ) u_sync (
      .i_clk(I_CORE_CLK),
      .i_rst_n(I_RST_N),
      .i_d({LINK.scl, LINK.sda}),
      .o_q(pin_s)
   );

   always_comb begin
      st_d = st_q;
      step_d = step_q;
      rd_d = rd_q;
      ack_d = ack_q;
      tx_d = tx_q;
      rx_d = rx_q;
      nack_d = nack_q;
      rsp_v_d = 1'b0;
      adv = (tick_q == 10'h000);
      tick_d = adv ? QTR_CYC - 10'h001 : tick_q - 10'h001;
      case (st_q)
         HS_IDLE, HS_HOLD: begin
            tick_d = QTR_CYC - 10'h001;
            step_d = 6'h00;
            if (I_CMD_VALID && rdy_q) begin
               case (I_CMD)
                  CMD_START: st_d = HS_START;
                  CMD_STOP: st_d = (st_q == HS_HOLD) ? HS_STOP : HS_IDLE;
                  CMD_WRITE: begin
                     st_d = (st_q == HS_HOLD) ? HS_BYTE : HS_IDLE;
                     rd_d = 1'b0;
                     tx_d = I_CMD_DATA;
                  end
                  default: begin
                     st_d = (st_q == HS_HOLD) ? HS_BYTE : HS_IDLE;
                     rd_d = 1'b1;
                     ack_d = I_CMD_ACK;
                     tx_d = 8'hff;
                  end
               endcase
            end
         end
         HS_START, HS_STOP: begin
            if (adv) begin
               step_d = step_q + 6'h01;
               if (step_q == `SEQ_LAST) begin
                  st_d = (st_q == HS_START) ? HS_HOLD : HS_IDLE;
               end
            end
         end
         HS_BYTE: begin
            if (adv) begin
               step_d = step_q + 6'h01;
               if (step_q[1:0] == 2'h2) begin
                  if (step_q[5:2] < `BIT_ACK) begin
                     rx_d = {rx_q[6:0], pin_s[0]};
                  end else begin
                     nack_d = pin_s[0];
                  end
               end
               if (step_q == `BYTE_LAST) begin
                  st_d = HS_HOLD;
                  rsp_v_d = 1'b1;
               end
            end
         end
         default: st_d = HS_IDLE;
      endcase
      // pin levels follow the next step so they leave flops directly
      bit_n = step_d[5:2];
      scl_oe_d = 1'b0;
      sda_oe_d = 1'b0;
      case (st_d)
         HS_HOLD: begin
            scl_oe_d = 1'b1;
            sda_oe_d = sda_oe_q;
         end
         HS_START: begin
            scl_oe_d = (step_d < 6'h02);
            sda_oe_d = (step_d >= 6'h04);
         end
         HS_STOP: begin
            scl_oe_d = (step_d < 6'h02);
            sda_oe_d = (step_d < 6'h04);
         end
         HS_BYTE: begin
            scl_oe_d = (step_d[1:0] < 2'h2);
            if (bit_n < `BIT_ACK) begin
               sda_oe_d = !tx_d[`BIT_MSB - bit_n[2:0]];
            end else begin
               sda_oe_d = rd_d && ack_d;
            end
         end
         default: begin
            scl_oe_d = 1'b0;
            sda_oe_d = 1'b0;
         end
      endcase
      rdy_d = (st_d == HS_HOLD) || (st_d == HS_IDLE && pin_s[1] && pin_s[0]);
   end

   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         st_q <= HS_IDLE;
         step_q <= 6'h00;
         tick_q <= 10'h000;
         rd_q <= 1'b0;
         ack_q <= 1'b0;
         tx_q <= 8'hff;
         rx_q <= 8'h00;
         scl_oe_q <= 1'b0;
         sda_oe_q <= 1'b0;
         rdy_q <= 1'b0;
         rsp_v_q <= 1'b0;
         nack_q <= 1'b0;
      end else begin
         st_q <= st_d;
         step_q <= step_d;
         tick_q <= tick_d;
         rd_q <= rd_d;
         ack_q <= ack_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         scl_oe_q <= scl_oe_d;
         sda_oe_q <= sda_oe_d;
         rdy_q <= rdy_d;
         rsp_v_q <= rsp_v_d;
         nack_q <= nack_d;
      end
   end

   assign O_CMD_READY = rdy_q;
   assign O_RSP_VALID = rsp_v_q;
   assign O_RSP_DATA = rx_q;
   assign O_RSP_NACK = nack_q;
   assign LINK.scl_o = 1'b0;
   assign LINK.scl_oe = scl_oe_q;
   assign LINK.m_sda_o = 1'b0;
   assign LINK.m_sda_oe = sda_oe_q;
endmodule

// [verification/rtc_link_monitor.sv]
// checker for the rtc two-wire link and the device user flags
// assumes the bench wires the link signals and device ports in by name
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module rtc_link_monitor (
   input wire logic I_CORE_CLK,
   input wire logic I_RST_N,
   input wire logic I_SUPPLY_OK,
   input wire logic scl,
   input wire logic sda,
   input wire logic d_sda_oe,
   input wire logic O_MAIN_SUPPLY,
   input wire logic O_FRAME_ACTIVE,
   input wire logic O_WR_STB
);
   logic scl_q, sda_q, first_q, first_d, wr_q, wr_d, rd_q, rd_d, nack_q, nack_d;
   logic [3:0] cnt_q, cnt_d;
   logic [7:0] sh_q, sh_d;
   logic rise, start_c, stop_c, match;
   // lines sampled on the core clock; the link is far slower, so no edge is missed
   assign rise = scl && !scl_q;
   assign start_c = scl && scl_q && sda_q && !sda;
   assign stop_c = scl && scl_q && !sda_q && sda;
   assign match = (sh_q[7:1] == `SLAVE_ADDR) && O_MAIN_SUPPLY;
   always_comb begin
      {cnt_d, sh_d, first_d, wr_d, rd_d, nack_d} = {cnt_q, sh_q, first_q, wr_q, rd_q, nack_q};
      if (start_c || stop_c) begin
         {cnt_d, first_d, wr_d, rd_d, nack_d} = {4'h0, 1'b1, 3'h0};
      end else if (rise && cnt_q == `BIT_ACK) begin
         cnt_d = 4'h0;
         first_d = 1'b0;
         if (first_q) begin
            wr_d = match && !sh_q[0];
            rd_d = match && sh_q[0];
         end else if (rd_q && sda) begin
            nack_d = 1'b1;
         end
      end else if (rise) begin
         cnt_d = cnt_q + 4'h1;
         sh_d = {sh_q[6:0], sda};
      end
   end
   always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         {scl_q, sda_q, cnt_q, sh_q, first_q, wr_q, rd_q, nack_q} <= {2'h3, 4'h0, 8'h00, 4'h0};
      end else begin
         {scl_q, sda_q, cnt_q, sh_q, first_q, wr_q, rd_q, nack_q} <=
            {scl, sda, cnt_d, sh_d, first_d, wr_d, rd_d, nack_d};
      end
   end
   default clocking cb @(posedge I_CORE_CLK);
   endclocking
   default disable iff (!I_RST_N);
   sequence s_slot;
      rise && cnt_q == `BIT_ACK;
   endsequence
   sequence s_addr_slot;
      s_slot ##0 first_q;
   endsequence
   sequence s_data_slot;
      s_slot ##0 !first_q;
   endsequence
   property p_frame_start;
      start_c && O_MAIN_SUPPLY |-> ##[1:6] O_FRAME_ACTIVE;
   endproperty
   property p_frame_stop;
      stop_c |-> ##[1:6] !O_FRAME_ACTIVE;
   endproperty
   property p_sda_hold;
      $changed(d_sda_oe) |-> !scl;
   endproperty
   property p_addr_ack;
      s_addr_slot ##0 match |-> d_sda_oe;
   endproperty
   property p_foreign;
      s_addr_slot ##0 !match |-> !d_sda_oe;
   endproperty
   property p_wr_ack;
      s_data_slot ##0 wr_q |-> d_sda_oe;
   endproperty
   property p_rd_release;
      s_data_slot ##0 rd_q |-> !d_sda_oe;
   endproperty
   property p_nack_silent;
      nack_q |-> !d_sda_oe;
   endproperty
   property p_supply_off;
      $fell(I_SUPPLY_OK) |-> ##[1:5] !O_MAIN_SUPPLY;
   endproperty
   property p_supply_on;
      $rose(I_SUPPLY_OK) |-> ##[1:5] O_MAIN_SUPPLY;
   endproperty
   property p_no_store_off;
      !O_MAIN_SUPPLY |-> !O_WR_STB;
   endproperty
   a_frame_start: assert property (p_frame_start)
      else $error("frame flag missing after start");
   a_frame_stop: assert property (p_frame_stop)
      else $error("frame flag stuck after stop");
   a_sda_hold: assert property (p_sda_hold)
      else $error("device data drive changed while clock high");
   a_addr_ack: assert property (p_addr_ack)
      else $error("own address not acknowledged");
   a_foreign: assert property (p_foreign)
      else $error("foreign address acknowledged");
   a_wr_ack: assert property (p_wr_ack)
      else $error("received byte not acknowledged");
   a_rd_release: assert property (p_rd_release)
      else $error("device holds data in the master ack slot");
   a_nack_silent: assert property (p_nack_silent)
      else $error("device drives data after master nack");
   a_supply_off: assert property (p_supply_off)
      else $error("supply loss not seen");
   a_supply_on: assert property (p_supply_on)
      else $error("supply return not seen");
   a_no_store_off: assert property (p_no_store_off)
      else $error("byte stored while supply low");
endmodule

// [verification/test_rtc_serial_slave_port.sv]
// bench joining the bus master and the rtc port across the link interface
// assumes the design files and rtc_port_cfg.svh are compiled first
`timescale 1ns/1ps
`include "rtc_port_cfg.svh"
module test_rtc_serial_slave_port;
   import rtc_port_pkg::*;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic supply_ok = 1'b1;
   logic cmd_valid = 1'b0;
   cmd_e cmd = CMD_START;
   logic [7:0] cmd_data = 8'h00;
   logic cmd_ack = 1'b0;
   logic cmd_ready, rsp_valid, rsp_nack, main_supply, frame_active, wr_stb;
   logic [7:0] rsp_data, wr_data;
   logic [`PTR_W-1:0] wr_addr;
   logic [10:0] stq[$];
   int n_mismatch = 0;
   int n_tests = 0;
   rtc_link_if link();
   rtc_serial_slave_port i_rtc_serial_slave_port (.I_CORE_CLK(core_clk), .I_RST_N(rst_n),
      .I_SUPPLY_OK(supply_ok), .LINK(link.device), .O_MAIN_SUPPLY(main_supply),
      .O_FRAME_ACTIVE(frame_active), .O_WR_STB(wr_stb), .O_WR_ADDR(wr_addr),
      .O_WR_DATA(wr_data));
   rtc_bus_master #(.QTR_CYC(`FAST_QTR_CYC)) i_rtc_bus_master (.I_CORE_CLK(core_clk),
      .I_RST_N(rst_n),
      .I_CMD_VALID(cmd_valid), .I_CMD(cmd), .I_CMD_DATA(cmd_data), .I_CMD_ACK(cmd_ack),
      .O_CMD_READY(cmd_ready), .O_RSP_VALID(rsp_valid), .O_RSP_DATA(rsp_data),
      .O_RSP_NACK(rsp_nack), .LINK(link.master));
   rtc_link_monitor i_rtc_link_monitor (.I_CORE_CLK(core_clk), .I_RST_N(rst_n),
      .I_SUPPLY_OK(supply_ok), .scl(link.scl), .sda(link.sda), .d_sda_oe(link.d_sda_oe),
      .O_MAIN_SUPPLY(main_supply), .O_FRAME_ACTIVE(frame_active), .O_WR_STB(wr_stb));
   always #2 core_clk = ~core_clk;
   // strobes are queued so a stray store shows up as a leftover entry
   always @(posedge core_clk) begin
      if (wr_stb === 1'b1) begin
         stq.push_back({wr_addr, wr_data});
      end
   end
   task automatic final_report;
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: flag %h expected %h", $time, got, exp);
      end
   endtask
   // a handshake that never comes ends the run after 30000 core clock cycles
   task automatic wait_for(ref logic flag);
      int i;
      for (i = 0; i < 30000 && flag !== 1'b1; i++) begin
         @(negedge core_clk);
      end
      chk_bit(flag, 1'b1);
      if (flag !== 1'b1) begin
         final_report();
      end
   endtask
   task automatic send(input cmd_e c, input logic [7:0] d, input logic a);
      wait_for(cmd_ready);
      cmd_valid = 1'b1;
      cmd = c;
      cmd_data = d;
      cmd_ack = a;
      @(negedge core_clk);
      cmd_valid = 1'b0;
      if (c == CMD_WRITE || c == CMD_READ) begin
         wait_for(rsp_valid);
      end
   endtask
   task automatic start;
      send(CMD_START, 8'h00, 1'b0);
      wait_for(cmd_ready);
   endtask
   task automatic stop;
      send(CMD_STOP, 8'h00, 1'b0);
      wait_for(cmd_ready);
      chk_bit(frame_active, 1'b0);
   endtask
   task automatic wr(input logic [7:0] d, input logic nack);
      send(CMD_WRITE, d, 1'b0);
      chk_bit(rsp_nack, nack);
   endtask
   task automatic rd(input logic a, input logic [7:0] exp);
      send(CMD_READ, 8'h00, a);
      chk_byte(rsp_data, exp);
   endtask
   task automatic stored(input logic [2:0] a, input logic [7:0] d);
      logic [10:0] e;
      e = (stq.size() > 0) ? stq.pop_front() : 11'bx;
      chk_byte({5'h00, e[10:8]}, {5'h00, a});
      chk_byte(e[7:0], d);
   endtask
   initial begin
      repeat (8) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (8) @(negedge core_clk);
      chk_bit(main_supply, 1'b1);
      // write from the top location so the second byte wraps
      start();
      chk_bit(frame_active, 1'b1);
      wr(8'hd0, 1'b0);
      wr(8'h07, 1'b0);
      wr(8'ha5, 1'b0);
      stored(3'h7, 8'ha5);
      wr(8'h3c, 1'b0);
      stored(3'h0, 8'h3c);
      stop();
      // addressed read through a repeated start, last byte unacknowledged
      start();
      wr(8'hd0, 1'b0);
      wr(8'h07, 1'b0);
      start();
      wr(8'hd1, 1'b0);
      rd(1'b1, 8'ha5);
      rd(1'b0, 8'h3c);
      stop();
      // plain read: the nack above must not have moved the pointer
      start();
      wr(8'hd1, 1'b0);
      rd(1'b0, 8'h3c);
      stop();
      start();
      wr(8'ha0, 1'b1);
      stop();
      // park the pointer away from zero, then lose the supply
      start();
      wr(8'hd0, 1'b0);
      wr(8'h03, 1'b0);
      stop();
      supply_ok = 1'b0;
      repeat (8) @(negedge core_clk);
      chk_bit(main_supply, 1'b0);
      start();
      wr(8'hd0, 1'b1);
      stop();
      supply_ok = 1'b1;
      repeat (8) @(negedge core_clk);
      chk_bit(main_supply, 1'b1);
      start();
      wr(8'hd1, 1'b0);
      rd(1'b0, 8'h3c);
      stop();
      chk_byte(8'(stq.size()), 8'h00);
      final_report();
   end
endmodule
